/* File: design/awc_halt_ctrl.sv */
// Halt mode selection, auto-wakeup and start-up sequencing
`timescale 1ns/1ps
`include "awc_map.svh"

module awc_halt_ctrl
    import awc_pkg::*;
#(
    parameter bit ZERO_IMMEDIATE = 1'b1
)
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // CPU core and interrupt controller
    input  wire logic        HALT_EXEC,
    input  wire logic        RTC_IRQ_ENABLE,
    input  wire logic        RTC_IRQ,
    input  wire logic        HALT_EXIT_IRQ,
    output logic             CC_MASK_WR,
    output logic      [1:0]  CC_MASK_VAL,
    output logic             AUTOWAKE_IRQ,
    output logic             RESET_FETCH,
    // Options and watchdog
    input  wire logic        STARTUP_LONG_OPT,
    input  wire logic        WDG_ACTIVE,
    input  wire logic        WDG_HALT_OPT,
    output logic             WDG_RESET_REQ,
    // Clock gating
    output logic             MAIN_OSC_EN,
    output logic             TIMEBASE_CLK_EN,
    output logic             CPU_CLK_EN,
    output logic             PERIPH_CLK_EN,
    output logic             WAKE_RC_EN,
    output logic      [2:0]  HALT_STATE,
    // Wake RC oscillator and timer A
    input  wire logic        WAKE_RC_TICK,
    output logic             TIMER_CAP2
);

    typedef struct packed {
        awc_state_t  state;
        logic [12:0] cnt;
        logic        en;
        logic        meas;
        logic        flag;
        logic [7:0]  pr;
        logic [31:0] rdata;
        logic        wr_csr;
        logic        wr_pr;
        logic        cc_wr;
        logic [1:0]  cc_val;
        logic        wdg;
        logic        fetch;
        logic        cap2;
    } awc_ctl_t;

    awc_ctl_t r_r;
    awc_ctl_t r_nxt;
    logic     expired;
    logic     acc;
    logic     rd_csr;

    function automatic logic [9:0] reg_byte(input logic [7:0] idx);
        reg_byte = {idx, 2'b00};
    endfunction

    function automatic logic [12:0] dly_last(input logic long_sel);
        dly_last = long_sel ? `AWC_DLY_LONG - 13'd1 : `AWC_DLY_SHORT - 13'd1;
    endfunction

    //------------------------------------------------------------
    // Auto-wakeup delay
    //------------------------------------------------------------
    awc_wake_timer u_timer (
        .clk      (SYS_CLK),
        .rstn     (RESETN),
        .run      (r_r.state == S_AWH),
        .rc_tick  (WAKE_RC_TICK),
        .prescale (r_r.pr),
        .expired  (expired)
    );

    assign acc    = HSEL & HTRANS[1] & HREADY;
    assign rd_csr = acc & ~HWRITE & (HADDR[9:0] == reg_byte(`AWC_CSR_IDX));

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        r_nxt       = r_r;
        r_nxt.cc_wr = 1'b0;
        r_nxt.wdg   = 1'b0;
        r_nxt.fetch = 1'b0;
        r_nxt.cap2  = WAKE_RC_TICK & r_r.meas & (r_r.state == S_RUN);

        // Bus data phase of a write
        r_nxt.wr_csr = acc & HWRITE & (HADDR[9:0] == reg_byte(`AWC_CSR_IDX));
        r_nxt.wr_pr  = acc & HWRITE & (HADDR[9:0] == reg_byte(`AWC_PR_IDX));
        if (r_r.wr_csr) begin
            r_nxt.en   = HWDATA[`AWC_CSR_EN_BIT];
            r_nxt.meas = HWDATA[`AWC_CSR_MEAS_BIT];
        end
        if (r_r.wr_pr) begin
            if (HWDATA[7:0] != 8'h00 || ZERO_IMMEDIATE) begin
                r_nxt.pr = HWDATA[7:0];
            end
        end

        // Bus address phase of a read
        r_nxt.rdata = '0;
        if (acc & ~HWRITE) begin
            if (HADDR[9:0] == reg_byte(`AWC_CSR_IDX)) begin
                r_nxt.rdata[`AWC_CSR_EN_BIT]   = r_r.en;
                r_nxt.rdata[`AWC_CSR_MEAS_BIT] = r_r.meas;
                r_nxt.rdata[`AWC_CSR_FLAG_BIT] = r_r.flag;
            end else if (HADDR[9:0] == reg_byte(`AWC_PR_IDX)) begin
                r_nxt.rdata[7:0] = r_r.pr;
            end
        end

        // Flag: set wins over the clearing read
        if (rd_csr) begin
            r_nxt.flag = 1'b0;
        end
        if (expired) begin
            r_nxt.flag = 1'b1;
        end

        unique case (r_r.state)
            S_BOOT: begin
                r_nxt.cnt   = dly_last(STARTUP_LONG_OPT);
                r_nxt.state = S_START;
            end
            S_START: begin
                r_nxt.cnt = r_r.cnt - 13'd1;
                if (r_r.cnt == 13'd0) begin
                    r_nxt.fetch = 1'b1;
                    r_nxt.state = S_RUN;
                end
            end
            S_RUN: begin
                if (HALT_EXEC) begin
                    r_nxt.cc_wr = 1'b1;
                    if (RTC_IRQ_ENABLE) begin
                        r_nxt.state  = S_ACTH;
                        r_nxt.cc_val = `AWC_CC_ACTIVE;
                    end else begin
                        r_nxt.state  = r_r.en ? S_AWH : S_HALT;
                        r_nxt.cc_val = `AWC_CC_HALT;
                        r_nxt.wdg    = WDG_ACTIVE & WDG_HALT_OPT;
                    end
                end
            end
            S_ACTH: begin
                if (RTC_IRQ | HALT_EXIT_IRQ) begin
                    r_nxt.state = S_RUN;
                end
            end
            S_AWH, S_HALT: begin
                if (expired | HALT_EXIT_IRQ) begin
                    r_nxt.cnt   = dly_last(STARTUP_LONG_OPT);
                    r_nxt.state = S_OSCW;
                end
            end
            S_OSCW: begin
                r_nxt.cnt = r_r.cnt - 13'd1;
                if (r_r.cnt == 13'd0) begin
                    r_nxt.state = S_RUN;
                end
            end
            default: begin
                r_nxt.state = S_BOOT;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            r_r        <= '0;
            r_r.state  <= S_BOOT;
            r_r.pr     <= `AWC_PR_RST;
            r_r.cc_val <= `AWC_CC_HALT;
        end else begin
            r_r <= r_nxt;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign HRDATA        = r_r.rdata;
    assign HREADYOUT     = 1'b1;
    assign HRESP         = 1'b0;
    assign CC_MASK_WR    = r_r.cc_wr;
    assign CC_MASK_VAL   = r_r.cc_val;
    assign AUTOWAKE_IRQ  = r_r.flag;
    assign RESET_FETCH   = r_r.fetch;
    assign WDG_RESET_REQ = r_r.wdg;
    assign HALT_STATE    = r_r.state;
    assign TIMER_CAP2    = r_r.cap2;
    // Oscillator off only in the two deep halt states
    assign MAIN_OSC_EN     = (r_r.state != S_AWH) && (r_r.state != S_HALT);
    assign TIMEBASE_CLK_EN = (r_r.state == S_RUN) || (r_r.state == S_ACTH);
    assign CPU_CLK_EN      = (r_r.state == S_RUN);
    assign PERIPH_CLK_EN   = (r_r.state == S_RUN);
    assign WAKE_RC_EN      = (r_r.state == S_AWH) || (r_r.meas && r_r.state == S_RUN);

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    chk_active_entry: assert property (
        r_r.state == S_RUN && HALT_EXEC && RTC_IRQ_ENABLE |=> r_r.state == S_ACTH)
        else $error("active-halt not entered");

    chk_awake_entry: assert property (
        r_r.state == S_RUN && HALT_EXEC && !RTC_IRQ_ENABLE && r_r.en
        |=> r_r.state == S_AWH)
        else $error("autowake halt not entered");

    chk_plain_entry: assert property (
        r_r.state == S_RUN && HALT_EXEC && !RTC_IRQ_ENABLE && !r_r.en
        |=> r_r.state == S_HALT)
        else $error("plain halt not entered");

    chk_active_hold: assert property (
        r_r.state == S_ACTH && !RTC_IRQ && !HALT_EXIT_IRQ |=> r_r.state == S_ACTH)
        else $error("active-halt left without cause");

    chk_mask_clear: assert property (
        r_r.state == S_ACTH && $past(r_r.state) == S_RUN
        |-> CC_MASK_WR && CC_MASK_VAL == 2'b00)
        else $error("mask not cleared on active-halt");

    chk_mask_force: assert property (
        r_r.state == S_AWH && $past(r_r.state) == S_RUN
        |-> CC_MASK_WR && CC_MASK_VAL == 2'b10)
        else $error("mask not forced on autowake halt");

    chk_gate_active: assert property (
        r_r.state == S_ACTH |-> MAIN_OSC_EN && TIMEBASE_CLK_EN && !PERIPH_CLK_EN)
        else $error("active-halt gating wrong");

    chk_gate_awake: assert property (
        r_r.state == S_AWH |-> !MAIN_OSC_EN && WAKE_RC_EN && !CPU_CLK_EN)
        else $error("autowake halt gating wrong");

    chk_no_wdog: assert property (
        r_r.state == S_RUN && HALT_EXEC && RTC_IRQ_ENABLE |=> !WDG_RESET_REQ)
        else $error("watchdog reset from active-halt");

    chk_flag_wake: assert property (
        r_r.state == S_AWH && expired |=> AUTOWAKE_IRQ && r_r.state == S_OSCW)
        else $error("expiry did not set flag and wake");

    chk_read_clear: assert property (
        rd_csr && !expired |=> !AUTOWAKE_IRQ)
        else $error("status read did not clear flag");

    chk_stab_short: assert property (
        r_r.state == S_OSCW && $past(r_r.state) != S_OSCW && !$past(STARTUP_LONG_OPT)
        |-> ##255 r_r.state == S_OSCW ##1 r_r.state == S_RUN)
        else $error("short stabilisation delay wrong");

    chk_active_exit: assert property (
        r_r.state == S_ACTH && (RTC_IRQ || HALT_EXIT_IRQ) |=> r_r.state == S_RUN)
        else $error("active-halt not left on wake");

    chk_halt_exit: assert property (
        (r_r.state == S_AWH || r_r.state == S_HALT) && HALT_EXIT_IRQ |=> r_r.state == S_OSCW)
        else $error("halt not left on wake interrupt");

    chk_boot_load: assert property (
        r_r.state == S_BOOT |=> r_r.cnt == ($past(STARTUP_LONG_OPT) ? 13'd4095 : 13'd255))
        else $error("start-up delay length wrong");

    chk_boot_fetch: assert property (
        r_r.state == S_START && r_r.cnt == 13'd0 |=> RESET_FETCH && r_r.state == S_RUN)
        else $error("start-up delay end wrong");

    chk_fetch_only: assert property (
        RESET_FETCH |-> $past(r_r.state) == S_START)
        else $error("reset fetch outside start-up");

    chk_wdog_halt: assert property (
        r_r.state == S_RUN && HALT_EXEC && !RTC_IRQ_ENABLE
        |=> WDG_RESET_REQ == $past(WDG_ACTIVE && WDG_HALT_OPT))
        else $error("watchdog option not applied");

    chk_wdog_pulse: assert property (
        WDG_RESET_REQ |=> !WDG_RESET_REQ)
        else $error("watchdog request longer than a cycle");

    chk_mask_pulse: assert property (
        CC_MASK_WR |=> !CC_MASK_WR)
        else $error("mask load longer than a cycle");

    chk_cap_route: assert property (
        r_r.state == S_RUN && r_r.meas && WAKE_RC_TICK |=> TIMER_CAP2)
        else $error("RC tick not routed to capture");

    chk_cap_quiet: assert property (
        !r_r.meas |=> !TIMER_CAP2)
        else $error("capture pulse without measure");

    chk_rc_measure: assert property (
        r_r.state == S_RUN && r_r.meas |-> WAKE_RC_EN)
        else $error("RC not enabled for measure");

    chk_gate_plain: assert property (
        r_r.state == S_HALT |-> !MAIN_OSC_EN && !WAKE_RC_EN && !CPU_CLK_EN && !PERIPH_CLK_EN)
        else $error("plain halt gating wrong");

    chk_osc_wait: assert property (
        r_r.state == S_OSCW |-> MAIN_OSC_EN && !CPU_CLK_EN)
        else $error("stabilisation gating wrong");

    chk_zero_fire: assert property (
        r_r.state == S_AWH && r_r.pr == 8'h00 |-> ##[1:2] r_r.state == S_OSCW)
        else $error("zero prescale did not wake");

    chk_csr_read: assert property (
        rd_csr |=> HRDATA[31:3] == 29'h0 && HRDATA[2:0] == $past({r_r.flag, r_r.meas, r_r.en}))
        else $error("status read data wrong");

    chk_pr_write: assert property (
        r_r.wr_pr && HWDATA[7:0] != 8'h00 |=> r_r.pr == $past(HWDATA[7:0]))
        else $error("prescaler write lost");

    cov_active: cover property (r_r.state == S_ACTH ##1 r_r.state == S_RUN);
    cov_awake: cover property (r_r.state == S_AWH && expired);
    cov_read: cover property (rd_csr && r_r.flag);
    cov_halt: cover property (r_r.state == S_HALT ##1 r_r.state == S_OSCW);
    cov_zero: cover property (r_r.state == S_AWH && r_r.pr == 8'h00);

endmodule

/* File: design/awc_map.svh */
// Constants of the halt mode and auto-wakeup controller
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef AWC_MAP_SVH
`define AWC_MAP_SVH

// Register indices, byte address is four times the index
`define AWC_CSR_IDX       8'h2e
`define AWC_PR_IDX        8'h2f
`define AWC_CSR_RST       8'h00
`define AWC_PR_RST        8'hff
`define AWC_CSR_EN_BIT    0
`define AWC_CSR_MEAS_BIT  1
`define AWC_CSR_FLAG_BIT  2

// Timing counts
`define AWC_DLY_LONG      13'd4096
`define AWC_DLY_SHORT     13'd256
`define AWC_FIX_DIV_MAX   6'd63
`define AWC_RC_START      4'd4

// Interrupt mask values written on halt entry
`define AWC_CC_ACTIVE     2'b00
`define AWC_CC_HALT       2'b10

`endif

/* File: design/awc_pkg.sv */
// Types of the halt mode and auto-wakeup controller
package awc_pkg;

    typedef enum logic [2:0] {
        S_BOOT  = 3'b100,
        S_START = 3'b000,
        S_RUN   = 3'b001,
        S_AWH   = 3'b011,
        S_OSCW  = 3'b010,
        S_ACTH  = 3'b101,
        S_HALT  = 3'b111
    } awc_state_t;

    typedef struct packed {
        logic [3:0] st;
        logic [5:0] div;
        logic [7:0] pre;
        logic       done;
        logic       fire;
    } awc_tmr_t;

endpackage

/* File: design/awc_wake_timer.sv */
// Auto-wakeup delay counter on the wake RC ticks
`timescale 1ns/1ps
`include "awc_map.svh"

module awc_wake_timer
    import awc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Control
    input  wire logic       run,
    input  wire logic       rc_tick,
    input  wire logic [7:0] prescale,
    // Result
    output logic            expired
);

    awc_tmr_t r_r;
    awc_tmr_t r_nxt;

    always_comb begin
        r_nxt      = r_r;
        r_nxt.fire = 1'b0;
        if (!run) begin
            r_nxt.st   = '0;
            r_nxt.div  = '0;
            r_nxt.pre  = '0;
            r_nxt.done = 1'b0;
        end else if (!r_r.done) begin
            if (prescale == 8'h00) begin
                r_nxt.done = 1'b1;
                r_nxt.fire = 1'b1;
            end else if (rc_tick) begin
                if (r_r.st != `AWC_RC_START) begin
                    r_nxt.st = r_r.st + 4'h1;
                end else if (r_r.div != `AWC_FIX_DIV_MAX) begin
                    r_nxt.div = r_r.div + 6'h01;
                end else begin
                    r_nxt.div = '0;
                    if (r_r.pre == prescale - 8'h01) begin
                        r_nxt.done = 1'b1;
                        r_nxt.fire = 1'b1;
                    end else begin
                        r_nxt.pre = r_r.pre + 8'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign expired = r_r.fire;

endmodule

/* File: tb/awc_cpu_model.sv */
// CPU core, interrupt mask and wake RC oscillator model for the halt controller
`timescale 1ns/1ps

module awc_cpu_model (
    // Clock
    input  wire logic       clk,
    // Mask load from the halt controller
    input  wire logic       cc_wr,
    input  wire logic [1:0] cc_val,
    // Wake oscillator enable
    input  wire logic       rc_en,
    // Toward the halt controller and the bench
    output logic            halt_exec,
    output logic            rc_tick,
    output logic      [1:0] cc_mask
);
    logic [1:0] ph;

    initial begin
        halt_exec = 1'b0;
        rc_tick = 1'b0;
        cc_mask = 2'b10;
        ph = 2'b00;
    end

    // RC ticks once in four clocks, stopped while disabled
    always @(posedge clk) begin
        ph <= rc_en ? ph + 2'b01 : 2'b00;
        rc_tick <= rc_en && (ph == 2'b11);
        if (cc_wr) begin
            cc_mask <= cc_val;
        end
    end

    task automatic do_halt();
        @(posedge clk);
        halt_exec <= 1'b1;
        @(posedge clk);
        halt_exec <= 1'b0;
    endtask
endmodule

/* File: tb/halt_mode_autowake_control_bench.sv */
// Self-checking bench of the halt mode and auto-wakeup controller
`timescale 1ns/1ps
`include "awc_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end

module halt_mode_autowake_control_bench;
    import awc_pkg::*;
    localparam logic [31:0] A_CSR = 32'({`AWC_CSR_IDX, 2'b00});
    localparam logic [31:0] A_PR  = 32'({`AWC_PR_IDX, 2'b00});
    localparam logic [31:0] A_BAD = 32'h0000_00c0;
    logic            sys_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
    logic      [1:0] htrans = 2'b00;
    logic     [31:0] haddr = 32'h0, hwdata = 32'h0, e_v;
    logic            rtc_en = 1'b0, rtc_irq = 1'b0, exit_irq = 1'b0, wdg_act = 1'b0;
    logic            wdg_opt = 1'b0, long_opt = 1'b0;
    logic      [7:0] pr;
    wire logic [31:0] hrdata;
    wire logic       hready, hresp, cc_wr, irq, fetch, wdg_rst, osc_en, tb_en, cpu_en;
    wire logic       per_en, rc_en, rc_tick, cap2, halt_exec;
    wire logic [1:0] cc_val, cc_mask;
    wire logic [2:0] halt_state;
    int              mismatches = 0, n_checks = 0, n_tick = 0, n_osc = 0, k;
    logic     [31:0] exp_q[$];

    always #2.5 sys_clk = ~sys_clk;

    awc_halt_ctrl u_awc_halt_ctrl (.SYS_CLK(sys_clk), .RESETN(resetn), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .HALT_EXEC(halt_exec), .RTC_IRQ_ENABLE(rtc_en), .RTC_IRQ(rtc_irq),
        .HALT_EXIT_IRQ(exit_irq), .CC_MASK_WR(cc_wr), .CC_MASK_VAL(cc_val),
        .AUTOWAKE_IRQ(irq), .RESET_FETCH(fetch), .STARTUP_LONG_OPT(long_opt),
        .WDG_ACTIVE(wdg_act), .WDG_HALT_OPT(wdg_opt), .WDG_RESET_REQ(wdg_rst),
        .MAIN_OSC_EN(osc_en), .TIMEBASE_CLK_EN(tb_en), .CPU_CLK_EN(cpu_en),
        .PERIPH_CLK_EN(per_en), .WAKE_RC_EN(rc_en), .HALT_STATE(halt_state),
        .WAKE_RC_TICK(rc_tick), .TIMER_CAP2(cap2));

    awc_cpu_model u_awc_cpu_model (.clk(sys_clk), .cc_wr(cc_wr), .cc_val(cc_val),
        .rc_en(rc_en), .halt_exec(halt_exec), .rc_tick(rc_tick), .cc_mask(cc_mask));

    //------------------------------------------------------------
    // Monitors
    //------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rd_ph && hready) begin
            e_v = exp_q.pop_front();
            `CHK({hresp, hrdata}, {1'b0, e_v})
        end
        if (halt_state === S_AWH && rc_tick === 1'b1) n_tick++;
        if (halt_state === S_OSCW) n_osc++;
    end

    //------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= !w;
        if (!w) exp_q.push_back(d);
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd_ph <= 1'b0;
    endtask

    task automatic wait_st(input logic [2:0] s, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            #1;
        end while (halt_state !== s && n < 6000);
        if (n >= 6000) begin
            mismatches++;
            $display("wrong value at %0t: state wait ran out", $time);
        end
    endtask

    task automatic do_reset(input logic lng);
        resetn <= 1'b0;
        long_opt <= lng;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        wait_st(S_RUN, k);
        `CHK(k, (lng ? int'(`AWC_DLY_LONG) : int'(`AWC_DLY_SHORT)) + 1)
        `CHK(fetch, 1'b1)
        $display("test reset done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole run is near 14000 clocks; cut off far beyond that
    initial begin
        #200us;
        mismatches++;
        $display("wrong value at %0t: run did not finish", $time);
        close_out();
    end

    initial begin
        void'($urandom(32'h5954109f));
        do_reset(1'b0);
        bus(1'b0, A_CSR, 32'h0);
        bus(1'b0, A_PR, 32'hff);
        bus(1'b0, A_BAD, 32'h0);
        pr = 8'($urandom_range(255, 1));
        bus(1'b1, A_PR, {24'h0, pr});
        bus(1'b0, A_PR, {24'h0, pr});
        bus(1'b1, A_CSR, 32'hff);
        bus(1'b0, A_CSR, 32'h3);
        do @(posedge sys_clk); while (rc_tick !== 1'b1);
        #1;
        `CHK({rc_en, cap2}, 2'b11)
        $display("test registers and measure done");
        pr = 8'($urandom_range(3, 1));
        bus(1'b1, A_PR, {24'h0, pr});
        bus(1'b1, A_CSR, 32'h1);
        wdg_act <= 1'b1;
        n_tick = 0;
        n_osc = 0;
        u_awc_cpu_model.do_halt();
        #1;
        `CHK(halt_state, S_AWH)
        `CHK({cc_wr, cc_val}, 3'b110)
        `CHK({osc_en, cpu_en, per_en, rc_en, wdg_rst}, 5'b00010)
        wait_st(S_OSCW, k);
        `CHK({irq, osc_en}, 2'b11)
        `CHK(n_tick, int'(`AWC_RC_START) + 64 * int'(pr))
        wait_st(S_RUN, k);
        `CHK(n_osc, int'(`AWC_DLY_SHORT))
        `CHK(cc_mask, 2'b10)
        bus(1'b0, A_CSR, 32'h5);
        `CHK(irq, 1'b0)
        bus(1'b0, A_CSR, 32'h1);
        bus(1'b1, A_PR, 32'h0);
        bus(1'b0, A_PR, 32'h0);
        u_awc_cpu_model.do_halt();
        #1;
        `CHK(halt_state, S_AWH)
        wait_st(S_OSCW, k);
        `CHK(k, 2)
        `CHK(irq, 1'b1)
        wait_st(S_RUN, k);
        bus(1'b0, A_CSR, 32'h5);
        $display("test autowake done");
        rtc_en <= 1'b1;
        wdg_opt <= 1'b1;
        u_awc_cpu_model.do_halt();
        #1;
        `CHK(halt_state, S_ACTH)
        `CHK({cc_wr, cc_val}, 3'b100)
        `CHK({osc_en, tb_en, cpu_en, per_en, wdg_rst}, 5'b11000)
        repeat (20) @(posedge sys_clk);
        `CHK(halt_state, S_ACTH)
        rtc_irq <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(halt_state, S_RUN)
        @(posedge sys_clk);
        rtc_irq <= 1'b0;
        u_awc_cpu_model.do_halt();
        #1;
        `CHK(halt_state, S_ACTH)
        @(posedge sys_clk);
        do_reset(1'b1);
        $display("test active halt done");
        rtc_en <= 1'b0;
        u_awc_cpu_model.do_halt();
        #1;
        `CHK(halt_state, S_HALT)
        `CHK({osc_en, rc_en, wdg_rst, cc_val}, 5'b00110)
        @(posedge sys_clk);
        n_osc = 0;
        exit_irq <= 1'b1;
        wait_st(S_RUN, k);
        `CHK(n_osc, int'(`AWC_DLY_LONG))
        bus(1'b1, A_CSR, 32'h1);
        u_awc_cpu_model.do_halt();
        #1;
        `CHK(halt_state, S_AWH)
        wait_st(S_OSCW, k);
        `CHK(k, 1)
        wait_st(S_RUN, k);
        $display("test plain halt and pending wake done");
        close_out();
    end
endmodule
